// ### sra_assertions.sv
// port checker of the security register access block
`timescale 1ns/1ps
module sra_assertions #(
    parameter int ERASE_CYCLES = 10000,
    parameter int PROGRAM_CYCLES = 1000
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // serial pins
    input wire logic serialClk,
    input wire logic chipSelectN,
    input wire logic serialDataOut,
    input wire logic serialDataOutEn,
    // apb and status
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic busyFlag
);
    // ----------------------------------------
    // busy length, too long for a repetition
    // ----------------------------------------
    logic [31:0] busyLen;
    always_ff @(posedge clk) begin
        if (rst) begin
            busyLen <= 32'h0;
        end else begin
            busyLen <= busyFlag ? busyLen + 32'h1 : 32'h0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_enDrops; $rose(chipSelectN) |-> ##[1:5] !serialDataOutEn; endproperty
    a_enDrops: assert property (p_enDrops) else $error("output enable held after deselect");
    property p_enIdle; chipSelectN [*6] |-> !serialDataOutEn; endproperty
    a_enIdle: assert property (p_enIdle) else $error("output enabled while deselected");
    property p_dataOnFall; serialDataOutEn && $changed(serialDataOut) |-> !serialClk; endproperty
    a_dataOnFall: assert property (p_dataOnFall) else $error("read data moved in high phase");
    property p_busyAfterCs; $rose(busyFlag) |-> chipSelectN; endproperty
    a_busyAfterCs: assert property (p_busyAfterCs) else $error("busy rose inside a frame");
    property p_busyLen;
        $fell(busyFlag) |-> busyLen >= PROGRAM_CYCLES - 2 && busyLen <= ERASE_CYCLES + 2;
    endproperty
    a_busyLen: assert property (p_busyLen) else $error("busy length out of range");
    property p_busyBound; busyLen <= ERASE_CYCLES + 2; endproperty
    a_busyBound: assert property (p_busyBound) else $error("busy never ends");
    property p_oneWait; psel && penable && !pready |=> pready; endproperty
    a_oneWait: assert property (p_oneWait) else $error("apb answer late");
    property p_readyPulse; pready |=> !pready; endproperty
    a_readyPulse: assert property (p_readyPulse) else $error("pready longer than a cycle");
    property p_readyCause; $rose(pready) |-> $past(psel) && $past(penable); endproperty
    a_readyCause: assert property (p_readyCause) else $error("pready without access");
    property p_errAnswer; pslverr |-> pready && (pwrite || prdata == 32'h0); endproperty
    a_errAnswer: assert property (p_errAnswer) else $error("bad error answer");
    c_busy: cover property ($fell(busyFlag));
    c_readOut: cover property ($rose(serialDataOutEn));
    c_err: cover property (pslverr);
endmodule : sra_assertions

// ### sra_host_model.sv
// host serial controller driving the flash pins, mode 0
`timescale 1ns/1ps
module sra_host_model (
    // system clock pacing the pins
    input wire logic clk,
    // serial pins
    output logic serialClk,
    output logic chipSelectN,
    output logic serialDataIn,
    input wire logic serialDataOut,
    input wire logic serialDataOutEn
);
    initial begin
        serialClk = 1'h0;
        chipSelectN = 1'h1;
        serialDataIn = 1'h0;
    end
    task automatic waitClk(input int n);
        repeat (n) @(posedge clk);
    endtask : waitClk
    task automatic frameStart();
        @(posedge clk);
        chipSelectN <= 1'h0;
        waitClk(4);
    endtask : frameStart
    // half periods of 5 clk leave room for the 2-flop syncs
    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            serialClk <= 1'h0;
            serialDataIn <= tx[i];
            waitClk(5);
            // an undriven line reads as the inverse of its last value
            rx[i] = serialDataOutEn ? serialDataOut : ~serialDataOut;
            serialClk <= 1'h1;
            waitClk(5);
        end
    endtask : xbyte
    // clock parks low, data line no longer shows its last bit
    task automatic frameEnd();
        serialClk <= 1'h0;
        waitClk(4);
        chipSelectN <= 1'h1;
        serialDataIn <= ~serialDataIn;
        waitClk(8);
    endtask : frameEnd
endmodule : sra_host_model

// ### sra_params.svh
// constants of the security register access block
`ifndef SRA_PARAMS_SVH
`define SRA_PARAMS_SVH

// ----------------------------------------------------------------------------
// serial command codes
// ----------------------------------------------------------------------------
`define SRA_OP_WRITE_ENABLE 8'h06
`define SRA_OP_WRITE_DISABLE 8'h04
`define SRA_OP_READ_STATUS1 8'h05
`define SRA_OP_READ_STATUS2 8'h35
`define SRA_OP_ERASE 8'h44
`define SRA_OP_PROGRAM 8'h42
`define SRA_OP_READ 8'h48

// ----------------------------------------------------------------------------
// address decode and frame lengths
// ----------------------------------------------------------------------------
`define SRA_ADDR_TOP_BYTE 8'h00
`define SRA_ADDR_LOW_NIBBLE 4'h0
`define SRA_AREA_FIRST 4'h1
`define SRA_AREA_LAST 4'h3
`define SRA_ERASED_BYTE 8'hFF
`define SRA_LAST_ADDR_BYTE 3'h3
`define SRA_ERASE_FRAME_BYTES 3'h4
`define SRA_PROGRAM_MIN_BYTES 3'h5
`define SRA_SINGLE_BYTE 3'h1

// ----------------------------------------------------------------------------
// status byte fields
// ----------------------------------------------------------------------------
`define SRA_BUSY_BIT 0
`define SRA_LATCH_BIT 1
`define SRA_APB_LOCK_LSB 2
`define SRA_SR2_LOCK_LSB 3

// ----------------------------------------------------------------------------
// APB register map
// ----------------------------------------------------------------------------
`define SRA_REG_STATUS 12'h000
`define SRA_REG_LOCK 12'h004
`define SRA_LOCK_RESET 3'h0

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define SRA_CLK_MHZ 100
`define SRA_ERASE_TIME_US 100
`define SRA_PROGRAM_TIME_US 10
`define SRA_ERASE_CYCLES (`SRA_ERASE_TIME_US * `SRA_CLK_MHZ)
`define SRA_PROGRAM_CYCLES (`SRA_PROGRAM_TIME_US * `SRA_CLK_MHZ)

`endif

// ### sra_pkg.sv
// types shared by the security register access block
package sra_pkg;

    typedef enum logic [2:0] {
        SRA_OPCODE,
        SRA_ADDR,
        SRA_DUMMY,
        SRA_PROG_DATA,
        SRA_READ_OUT,
        SRA_STATUS_OUT,
        SRA_IGNORE
    } sra_phase_t;

    typedef enum logic [1:0] {
        SRA_IDLE,
        SRA_ERASING,
        SRA_PROGRAMMING
    } sra_cycle_t;

endpackage : sra_pkg

// ### sra_security_register_access.sv
// serial command engine for three one-time-protectable security areas
//
// Contract
// RULE_01 - erase is taken only while the write enable latch is set
// RULE_02 - erase frame is opcode 44h then a 24-bit address
// RULE_03 - area chosen by address bits 15-12 = 1..3, others zero; bits 7-0 offset
// RULE_04 - erase runs only if chip select rises right after the fourth byte
// RULE_05 - chip select rise after valid erase starts timed erase, busy held meanwhile
// RULE_06 - status reads stay answered while an erase runs
// RULE_07 - erase completion clears the write enable latch
// RULE_08 - erase aimed at a locked area does nothing
// RULE_09 - program aimed at a locked area leaves it unchanged
// RULE_10 - program is taken only while the write enable latch is set
// RULE_11 - program frame is opcode 42h, 24-bit address, then data bytes
// RULE_12 - one program writes 1 to 256 bytes; bits only fall from erased ones
// RULE_13 - host keeps chip select low through every program data byte
// RULE_14 - read frame is opcode 48h, 24-bit address, eight dummy clocks
// RULE_15 - opcode and address bits are sampled on serial clock rising edges
// RULE_16 - read data changes on falling edges, most significant bit first
// RULE_17 - read offset steps per byte and wraps from FFh to 00h in the area
// RULE_18 - read goes on until chip select rises
// RULE_19 - read arriving while busy is ignored and leaves the cycle alone
// RULE_20 - program bytes past 256 wrap within the addressed area
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "sra_params.svh"

module sra_security_register_access #(
    parameter int ERASE_CYCLES = `SRA_ERASE_CYCLES,
    parameter int PROGRAM_CYCLES = `SRA_PROGRAM_CYCLES,
    parameter int TIMER_W = 24
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // serial link pins
    input wire logic serialClk,
    input wire logic chipSelectN,
    input wire logic serialDataIn,
    output logic serialDataOut,
    output logic serialDataOutEn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // status
    output logic busyFlag
);

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    // area number 1..3, or 0 when the address names no security area
    function automatic logic [1:0] areaOf(input logic [23:0] a);
        if (a[23:16] == `SRA_ADDR_TOP_BYTE && a[11:8] == `SRA_ADDR_LOW_NIBBLE
                && a[15:12] >= `SRA_AREA_FIRST && a[15:12] <= `SRA_AREA_LAST) begin
            areaOf = a[13:12]; // [RULE_03]
        end else begin
            areaOf = 2'h0;
        end
    endfunction : areaOf

    function automatic logic [9:0] memIndex(input logic [1:0] area, input logic [7:0] off);
        memIndex = {area - 2'h1, off};
    endfunction : memIndex

    // ------------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------------
    logic sclkSyncA, sclkSyncB, sclkPrev;
    logic csSyncA, csSyncB, csPrev;
    logic sdiSyncA, sdiSyncB;

    always_ff @(posedge clk) begin
        if (rst) begin
            sclkSyncA <= 1'b0;
            sclkSyncB <= 1'b0;
            sclkPrev <= 1'b0;
            csSyncA <= 1'b1;
            csSyncB <= 1'b1;
            csPrev <= 1'b1;
            sdiSyncA <= 1'b0;
            sdiSyncB <= 1'b0;
        end else begin
            sclkSyncA <= serialClk;
            sclkSyncB <= sclkSyncA;
            sclkPrev <= sclkSyncB;
            csSyncA <= chipSelectN;
            csSyncB <= csSyncA;
            csPrev <= csSyncB;
            sdiSyncA <= serialDataIn;
            sdiSyncB <= sdiSyncA;
        end
    end

    logic csActive, csRise, sclkRise, sclkFall;
    assign csActive = ~csSyncB;
    assign csRise = csSyncB & ~csPrev;
    assign sclkRise = sclkSyncB & ~sclkPrev & csActive; // [RULE_15]
    assign sclkFall = ~sclkSyncB & sclkPrev & csActive;

    // ------------------------------------------------------------------------
    // shared state
    // ------------------------------------------------------------------------
    sra_pkg::sra_phase_t phase;
    sra_pkg::sra_cycle_t cycle;
    logic [2:0] bitCount;
    logic [2:0] byteCount;
    logic [7:0] shiftIn;
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [1:0] areaSel;
    logic [7:0] offset;
    logic [7:0] outByte;
    logic [TIMER_W-1:0] timer;
    logic writeEnable;
    logic [2:0] lockBits;
    logic [7:0] mem [0:767];

    logic [7:0] next_byte;
    logic [23:0] next_addr;
    logic byteDone, areaLocked, progByteOk, cycleDone;
    logic [7:0] status1, status2;

    assign next_byte = {shiftIn[6:0], sdiSyncB};
    assign next_addr = {addr[15:0], next_byte};
    assign byteDone = sclkRise && bitCount == 3'h7;
    assign areaLocked = (areaSel != 2'h0) && lockBits[areaSel - 2'h1];
    assign cycleDone = (cycle != sra_pkg::SRA_IDLE) && timer == '0;
    assign status1 = {6'h00, writeEnable, busyFlag};
    assign status2 = {2'h0, lockBits, 3'h0};
    // bytes land as they arrive; a locked or unlatched frame never touches the area
    assign progByteOk = byteDone && phase == sra_pkg::SRA_PROG_DATA
        && writeEnable && !areaLocked && !busyFlag; // [RULE_09] [RULE_10]

    // ------------------------------------------------------------------------
    // frame decoder, clocked by rising serial clock
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            phase <= sra_pkg::SRA_OPCODE;
            bitCount <= 3'h0;
            byteCount <= 3'h0;
            shiftIn <= 8'h00;
            opcode <= 8'h00;
            addr <= 24'h000000;
            areaSel <= 2'h0;
            offset <= 8'h00;
            outByte <= 8'h00;
        end else if (!csActive) begin
            // chip select high closes any frame, a read included [RULE_18]
            phase <= sra_pkg::SRA_OPCODE;
            bitCount <= 3'h0;
            byteCount <= 3'h0;
        end else if (sclkRise) begin
            shiftIn <= next_byte;
            bitCount <= bitCount + 3'h1;
            if (bitCount == 3'h7 && byteCount != 3'h7) begin
                byteCount <= byteCount + 3'h1;
            end
            if (bitCount == 3'h7) begin
                case (phase)
                    sra_pkg::SRA_OPCODE: begin
                        opcode <= next_byte;
                        if (next_byte == `SRA_OP_READ_STATUS1) begin
                            outByte <= status1; // [RULE_06]
                            phase <= sra_pkg::SRA_STATUS_OUT;
                        end else if (next_byte == `SRA_OP_READ_STATUS2) begin
                            outByte <= status2;
                            phase <= sra_pkg::SRA_STATUS_OUT;
                        end else if (busyFlag) begin
                            // a frame begun while busy must not act when chip select rises later
                            opcode <= 8'h00;
                            phase <= sra_pkg::SRA_IGNORE; // [RULE_19]
                        end else if (next_byte == `SRA_OP_ERASE
                                || next_byte == `SRA_OP_PROGRAM
                                || next_byte == `SRA_OP_READ) begin
                            phase <= sra_pkg::SRA_ADDR; // [RULE_02] [RULE_11] [RULE_14]
                        end else begin
                            phase <= sra_pkg::SRA_IGNORE;
                        end
                    end
                    sra_pkg::SRA_ADDR: begin
                        addr <= next_addr;
                        if (byteCount == `SRA_LAST_ADDR_BYTE) begin
                            areaSel <= areaOf(next_addr);
                            offset <= next_byte;
                            if (areaOf(next_addr) == 2'h0 || opcode == `SRA_OP_ERASE) begin
                                phase <= sra_pkg::SRA_IGNORE;
                            end else if (opcode == `SRA_OP_READ) begin
                                phase <= sra_pkg::SRA_DUMMY;
                            end else begin
                                phase <= sra_pkg::SRA_PROG_DATA;
                            end
                        end
                    end
                    sra_pkg::SRA_DUMMY: begin
                        // eight dummy clocks done, first byte ready for the next fall
                        outByte <= mem[memIndex(areaSel, offset)];
                        phase <= sra_pkg::SRA_READ_OUT;
                    end
                    sra_pkg::SRA_PROG_DATA: begin
                        offset <= offset + 8'h01; // [RULE_20]
                    end
                    sra_pkg::SRA_READ_OUT: begin
                        offset <= offset + 8'h01; // [RULE_17]
                        outByte <= mem[memIndex(areaSel, offset + 8'h01)];
                    end
                    sra_pkg::SRA_STATUS_OUT: begin
                        outByte <= (opcode == `SRA_OP_READ_STATUS1) ? status1 : status2;
                    end
                    default: begin
                        phase <= sra_pkg::SRA_IGNORE;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // output driver, changes on falling serial clock
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            serialDataOut <= 1'b0;
            serialDataOutEn <= 1'b0;
        end else if (!csActive) begin
            serialDataOutEn <= 1'b0;
        end else if (sclkFall && (phase == sra_pkg::SRA_READ_OUT
                || phase == sra_pkg::SRA_STATUS_OUT)) begin
            serialDataOut <= outByte[3'h7 - bitCount]; // [RULE_16]
            serialDataOutEn <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // array: program and erase
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            // sim start only; a real array keeps its cells across reset
            for (int i = 0; i < 768; i++) begin
                mem[i] <= `SRA_ERASED_BYTE;
            end
        end else if (cycleDone && cycle == sra_pkg::SRA_ERASING) begin
            for (int i = 0; i < 256; i++) begin
                mem[memIndex(areaSel, 8'(i))] <= `SRA_ERASED_BYTE; // [RULE_05]
            end
        end else if (progByteOk) begin
            // programming only clears bits: each cell takes the AND of its old value and the new byte
            mem[memIndex(areaSel, offset)] <= mem[memIndex(areaSel, offset)] & next_byte; // [RULE_12]
        end
    end

    // ------------------------------------------------------------------------
    // self-timed cycles and write enable latch
    // ------------------------------------------------------------------------
    logic frameOnBoundary;
    assign frameOnBoundary = csRise && bitCount == 3'h0;

    always_ff @(posedge clk) begin
        if (rst) begin
            cycle <= sra_pkg::SRA_IDLE;
            timer <= '0;
            busyFlag <= 1'b0;
            writeEnable <= 1'b0;
        end else if (busyFlag) begin
            if (cycleDone) begin
                cycle <= sra_pkg::SRA_IDLE;
                busyFlag <= 1'b0;
                writeEnable <= 1'b0; // [RULE_07]
            end else begin
                timer <= timer - TIMER_W'(1);
            end
        end else if (frameOnBoundary) begin
            if (opcode == `SRA_OP_WRITE_ENABLE && byteCount == `SRA_SINGLE_BYTE) begin
                writeEnable <= 1'b1;
            end else if (opcode == `SRA_OP_WRITE_DISABLE && byteCount == `SRA_SINGLE_BYTE) begin
                writeEnable <= 1'b0;
            end else if (opcode == `SRA_OP_ERASE && byteCount == `SRA_ERASE_FRAME_BYTES
                    && writeEnable && areaSel != 2'h0 && !areaLocked) begin
                // [RULE_01] [RULE_04] [RULE_08]
                cycle <= sra_pkg::SRA_ERASING;
                timer <= TIMER_W'(ERASE_CYCLES - 1);
                busyFlag <= 1'b1; // [RULE_05]
            end else if (opcode == `SRA_OP_PROGRAM && byteCount >= `SRA_PROGRAM_MIN_BYTES
                    && writeEnable && areaSel != 2'h0 && !areaLocked) begin
                // the data already sits in the array; this only models its write time [RULE_13]
                cycle <= sra_pkg::SRA_PROGRAMMING;
                timer <= TIMER_W'(PROGRAM_CYCLES - 1);
                busyFlag <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------------
    logic apbAccess, apbWriteNow;
    assign apbAccess = psel && penable;
    assign apbWriteNow = apbAccess && pready && pwrite;

    // lock bits are one-time: software can set them, only reset clears them
    always_ff @(posedge clk) begin
        if (rst) begin
            lockBits <= `SRA_LOCK_RESET;
        end else if (apbWriteNow && paddr == `SRA_REG_LOCK) begin
            lockBits <= lockBits | pwdata[2:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (apbAccess && !pready) begin
            pready <= 1'b1;
            pslverr <= paddr != `SRA_REG_STATUS && paddr != `SRA_REG_LOCK;
            if (pwrite) begin
                prdata <= 32'h00000000;
            end else if (paddr == `SRA_REG_STATUS) begin
                prdata <= {27'h0000000, lockBits, writeEnable, busyFlag};
            end else if (paddr == `SRA_REG_LOCK) begin
                prdata <= {29'h00000000, lockBits};
            end else begin
                prdata <= 32'h00000000;
            end
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule : sra_security_register_access

// ### tb_security_register_access.sv
// self-checking bench of the security register access block
`timescale 1ns/1ps
module tb_security_register_access;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, busyFlag, sawEn;
    logic serialClk, chipSelectN, serialDataIn, serialDataOut, serialDataOutEn;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] rxq[$];
    int nMismatch = 0;
    int nCompared = 0;
    int cycles = 0;
    sra_security_register_access #(.ERASE_CYCLES(1500), .PROGRAM_CYCLES(300)) DUT (
        .clk(clk), .rst(rst), .serialClk(serialClk), .chipSelectN(chipSelectN),
        .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
        .serialDataOutEn(serialDataOutEn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .busyFlag(busyFlag));
    sra_host_model host (.clk(clk), .serialClk(serialClk), .chipSelectN(chipSelectN),
        .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
        .serialDataOutEn(serialDataOutEn));
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (serialDataOutEn === 1'h1) sawEn <= 1'h1;
        if (cycles == 80000) begin
            nMismatch++;
            finalReport();
        end
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            nMismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic e);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        rd = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic frame(input logic [7:0] tx[$], input int nRead);
        logic [7:0] r;
        rxq = {};
        host.frameStart();
        foreach (tx[i]) host.xbyte(tx[i], r);
        repeat (nRead) begin
            host.xbyte(8'h00, r);
            rxq.push_back(r);
        end
        host.frameEnd();
    endtask : frame
    task automatic status(input logic [7:0] exp, input string name);
        frame({8'h05}, 1);
        check(name, {24'h0, rxq[0]}, {24'h0, exp});
    endtask : status
    task automatic waitIdle();
        for (int i = 0; i < 60; i++) begin
            frame({8'h05}, 1);
            if (rxq[0][0] === 1'h0) break;
        end
    endtask : waitIdle
    // area byte carries address bits 15-8
    task automatic readCheck(input logic [7:0] ah, input logic [7:0] off, input logic [7:0] exp[$]);
        frame({8'h48, 8'h00, ah, off, 8'h00}, exp.size());
        foreach (exp[i]) check("read data", {24'h0, rxq[i]}, {24'h0, exp[i]});
    endtask : readCheck
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        logic e;
        apb(1'h0, 12'h000, 32'h0, e);
        check("status reg", rd, 32'h0);
        apb(1'h0, 12'h004, 32'h0, e);
        check("lock reg", rd, 32'h0);
        apb(1'h0, 12'h008, 32'h0, e);
        check("unmapped err", {31'h0, e}, 32'h1);
        check("unmapped data", rd, 32'h0);
    endtask : t_reset
    task automatic t_program();
        frame({8'h06}, 0);
        status(8'h02, "latch set");
        frame({8'h42, 8'h00, 8'h20, 8'hFE, 8'hA5, 8'h3C, 8'h5A}, 0);
        status(8'h03, "program busy");
        waitIdle();
        status(8'h00, "latch after program");
        readCheck(8'h20, 8'hFE, {8'hA5, 8'h3C, 8'h5A, 8'hFF});
    endtask : t_program
    task automatic t_refused();
        frame({8'h42, 8'h00, 8'h10, 8'h00, 8'h00}, 0);
        status(8'h00, "program without latch");
        frame({8'h06}, 0);
        frame({8'h42, 8'h00, 8'h11, 8'h00, 8'h00}, 0);
        status(8'h02, "bad area program");
        frame({8'h04}, 0);
        status(8'h00, "latch cleared");
        readCheck(8'h10, 8'h00, {8'hFF});
    endtask : t_refused
    task automatic t_erase();
        frame({8'h06}, 0);
        frame({8'h42, 8'h00, 8'h30, 8'h00, 8'h12}, 0);
        waitIdle();
        frame({8'h44, 8'h00, 8'h30, 8'h00}, 0);
        status(8'h00, "erase without latch");
        frame({8'h06}, 0);
        frame({8'h44, 8'h00, 8'h30, 8'h00, 8'h00}, 0);
        status(8'h02, "erase overlong frame");
        readCheck(8'h30, 8'h00, {8'h12});
        frame({8'h44, 8'h00, 8'h20, 8'h00}, 0);
        status(8'h03, "erase busy poll");
        waitIdle();
        status(8'h00, "latch after erase");
        readCheck(8'h20, 8'hFE, {8'hFF, 8'hFF});
    endtask : t_erase
    task automatic t_lock();
        logic e;
        apb(1'h1, 12'h004, 32'h4, e);
        apb(1'h1, 12'h004, 32'h0, e);
        apb(1'h0, 12'h004, 32'h0, e);
        check("lock sticky", rd, 32'h4);
        frame({8'h35}, 1);
        check("status2 lock", {24'h0, rxq[0]}, 32'h20);
        frame({8'h06}, 0);
        frame({8'h44, 8'h00, 8'h30, 8'h00}, 0);
        status(8'h02, "locked erase");
        frame({8'h42, 8'h00, 8'h30, 8'h01, 8'h00}, 0);
        status(8'h02, "locked program");
        readCheck(8'h30, 8'h00, {8'h12, 8'hFF});
        apb(1'h0, 12'h000, 32'h0, e);
        check("status reg", rd, 32'h12);
    endtask : t_lock
    task automatic t_busyRead();
        frame({8'h44, 8'h00, 8'h10, 8'h00}, 0);
        sawEn = 1'h0;
        frame({8'h48, 8'h00, 8'h10, 8'h00, 8'h00}, 2);
        check("read while busy", {31'h0, sawEn}, 32'h0);
        status(8'h03, "erase kept");
        check("busy pin", {31'h0, busyFlag}, 32'h1);
        waitIdle();
        readCheck(8'h10, 8'h00, {8'hFF});
    endtask : t_busyRead
    task automatic finalReport();
        if (nMismatch == 0 && nCompared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finalReport
    initial begin
        rst = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        sawEn = 1'h0;
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        repeat (4) @(posedge clk);
        t_reset();
        t_program();
        t_refused();
        t_erase();
        t_lock();
        t_busyRead();
        finalReport();
    end
endmodule : tb_security_register_access
bind sra_security_register_access sra_assertions #(.ERASE_CYCLES(ERASE_CYCLES),
    .PROGRAM_CYCLES(PROGRAM_CYCLES)) chk (.clk(clk), .rst(rst), .serialClk(serialClk),
    .chipSelectN(chipSelectN), .serialDataOut(serialDataOut),
    .serialDataOutEn(serialDataOutEn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .busyFlag(busyFlag));
